// file: mie_core.sv
// instruction-subset execution core with an AHB-Lite register slave
`timescale 1ns/1ps
`include "mie_map.svh"

// Overview of operation
// - rotate_right_via_link shifts the operand right by one through link and changes only link.
// - for register operands dest 0 writes the accumulator, dest 1 writes the register (0..127).
// - return pops the stack into the program counter, takes two cycles, touches no flags.
// - sleep clears the watchdog_counter to 00h and clears its prescaler.
// - sleep sets watchdog_expired_bit and the sleep status bit and clears power_down_bit, no other status bit.
// - after sleep the core is in low power with the oscillator halted.
// - literal_minus_acc puts literal minus accumulator in the accumulator, sets link, half, null.
// - regfile_minus_acc puts register minus accumulator in destination, sets link, half, null.
// - literal_xor_acc puts accumulator xor literal in the accumulator, sets only null.
// - regfile_xor_acc puts accumulator xor register in the destination, sets only null.
// - nibble_exchange swaps the register nibbles into the destination, flags untouched.
module mie_core
   import mie_pkg::*;
#(
   parameter int RF_DEPTH  = 128,
   parameter int STK_DEPTH = 8
) (
   input  wire logic        ref_clk,    // core clock, 200 MHz
   input  wire logic        sys_rst,    // async reset, active high
   input  wire logic        hsel,       // slave select
   input  wire logic [31:0] haddr,      // byte address
   input  wire logic [1:0]  htrans,     // transfer type
   input  wire logic        hwrite,     // write when high
   input  wire logic [2:0]  hsize,      // word only
   input  wire logic [31:0] hwdata,     // write data
   input  wire logic        hready,     // bus ready
   output logic      [31:0] hrdata,     // read data
   output logic             hreadyout,  // slave ready
   output logic             hresp,      // always okay
   output logic             osc_halted  // main oscillator stopped
);
   localparam int SPW = $clog2(STK_DEPTH);

   function automatic mie_alu_s sub8(input logic [7:0] a, input logic [7:0] b);
      mie_alu_s   r;
      logic [8:0] d;
      d = {1'b0, a} - {1'b0, b};
      r.value = d[7:0];
      r.flags.link = ~d[8];
      r.flags.half_borrow = (a[3:0] >= b[3:0]);
      r.flags.null_result = (d[7:0] == 8'h00);
      return r;
   endfunction

   // state
   logic [7:0]     rf [RF_DEPTH];
   logic [12:0]    stk [STK_DEPTH];
   logic [7:0]     acc, next_acc;
   logic [12:0]    pc, next_pc;
   logic [SPW-1:0] sp, next_sp;
   mie_flags_s     flg, next_flg;
   logic           wd_exp, next_wd_exp;
   logic           pwr_dn, next_pwr_dn;
   logic           asleep, next_asleep;
   logic [7:0]     wdog, next_wdog;
   logic [7:0]     presc, next_presc;
   mie_exec_e      ex, next_ex;
   logic           rf_we;
   logic [6:0]     rf_wa;
   logic [7:0]     rf_wd;
   logic           stk_we;
   // bus
   logic           pend, next_pend;
   logic           pwr, next_pwr;
   logic [11:0]    paddr, next_paddr;
   logic [31:0]    next_hrdata;
   logic           next_hreadyout;
   logic           next_osc;

   mie_cmd_s cmd;
   logic     busy, go, wr_ok;
   logic [7:0] opnd;
   mie_alu_s   res;

   assign busy  = (ex == EX_RET2);
   assign wr_ok = pend && pwr && !busy;
   assign cmd   = mie_cmd_s'(hwdata);
   assign go    = wr_ok && (paddr == 12'(`MIE_OFS_CMD)) && !asleep;
   assign opnd  = rf[cmd.index];

   always_comb begin
      next_acc    = acc;
      next_pc     = pc;
      next_sp     = sp;
      next_flg    = flg;
      next_wd_exp = wd_exp;
      next_pwr_dn = pwr_dn;
      next_asleep = asleep;
      next_ex     = EX_IDLE;
      {next_wdog, next_presc} = {wdog, presc} + 16'h0001;
      rf_we  = 1'b0;
      rf_wa  = cmd.index;
      rf_wd  = 8'h00;
      stk_we = 1'b0;
      res.value = opnd;
      res.flags = flg;
      if (go) begin
         unique case (cmd.opcode)
            `MIE_OP_ROTR: begin
               res.value = {flg.link, opnd[7:1]};
               res.flags.link = opnd[0];
            end
            `MIE_OP_RET: begin
               next_sp = sp - 1'b1;
               next_pc = stk[sp - 1'b1];
               next_ex = EX_RET2;
            end
            `MIE_OP_SLEEP: begin
               {next_wdog, next_presc} = {`MIE_WDOG_CLR, 8'h00};
               next_wd_exp = 1'b1;
               next_pwr_dn = 1'b0;
               next_asleep = 1'b1;
            end
            `MIE_OP_SUBL: res = sub8(cmd.literal, acc);
            `MIE_OP_SUBF: res = sub8(opnd, acc);
            `MIE_OP_XORL: begin
               res.value = acc ^ cmd.literal;
               res.flags.null_result = (res.value == 8'h00);
            end
            `MIE_OP_XORF: begin
               res.value = acc ^ opnd;
               res.flags.null_result = (res.value == 8'h00);
            end
            `MIE_OP_SWAP: res.value = {opnd[3:0], opnd[7:4]};
            default: ;
         endcase
         unique case (cmd.opcode)
            `MIE_OP_SUBL, `MIE_OP_XORL: next_acc = res.value;
            `MIE_OP_ROTR, `MIE_OP_SUBF, `MIE_OP_XORF, `MIE_OP_SWAP: begin
               next_flg = res.flags;
               if (cmd.dest) begin
                  rf_we = 1'b1;
                  rf_wd = res.value;
               end else begin
                  next_acc = res.value;
               end
            end
            default: ;
         endcase
         if (cmd.opcode == `MIE_OP_SUBL || cmd.opcode == `MIE_OP_XORL)
            next_flg = res.flags;
      end else if (wr_ok) begin
         if (paddr == 12'(`MIE_OFS_ACC))
            next_acc = hwdata[7:0];
         if (paddr == 12'(`MIE_OFS_STATUS)) begin
            next_flg.link        = hwdata[`MIE_ST_LINK];
            next_flg.half_borrow = hwdata[`MIE_ST_HALF];
            next_flg.null_result = hwdata[`MIE_ST_NULL];
            next_wd_exp          = hwdata[`MIE_ST_WDEXP];
            next_pwr_dn          = hwdata[`MIE_ST_PWRDN];
         end
         if (paddr == 12'(`MIE_OFS_PC))
            next_pc = hwdata[12:0];
         if (paddr == 12'(`MIE_OFS_PUSH)) begin
            stk_we  = 1'b1;
            next_sp = sp + 1'b1;
         end
         if (paddr == 12'(`MIE_OFS_WAKE))
            next_asleep = 1'b0;
         if (paddr >= `MIE_RF_BASE && paddr < `MIE_RF_BASE + 12'(4 * RF_DEPTH)) begin
            rf_we = 1'b1;
            rf_wa = paddr[8:2];
            rf_wd = hwdata[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc    <= `MIE_RST_ACC;
         pc     <= `MIE_RST_PC;
         sp     <= '0;
         flg    <= '0;
         wd_exp <= `MIE_RST_WDEXP;
         pwr_dn <= `MIE_RST_PWRDN;
         asleep <= 1'b0;
         wdog   <= 8'h00;
         presc  <= 8'h00;
         ex     <= EX_IDLE;
      end else begin
         acc    <= next_acc;
         pc     <= next_pc;
         sp     <= next_sp;
         flg    <= next_flg;
         wd_exp <= next_wd_exp;
         pwr_dn <= next_pwr_dn;
         asleep <= next_asleep;
         wdog   <= next_wdog;
         presc  <= next_presc;
         ex     <= next_ex;
      end
   end

   // arrays carry no reset; software initialises them
   always_ff @(posedge ref_clk) begin
      if (rf_we)
         rf[rf_wa] <= rf_wd;
      if (stk_we)
         stk[sp] <= hwdata[12:0];
   end

   function automatic logic [31:0] rd_word(input logic [11:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (a)
         12'(`MIE_OFS_ACC):    w[7:0] = acc;
         12'(`MIE_OFS_STATUS): begin
            w[`MIE_ST_LINK]  = flg.link;
            w[`MIE_ST_HALF]  = flg.half_borrow;
            w[`MIE_ST_NULL]  = flg.null_result;
            w[`MIE_ST_WDEXP] = wd_exp;
            w[`MIE_ST_PWRDN] = pwr_dn;
            w[`MIE_ST_SLEEP] = asleep;
            w[`MIE_ST_BUSY]  = busy;
         end
         12'(`MIE_OFS_PC):     w[12:0] = pc;
         12'(`MIE_OFS_PUSH):   w[SPW-1:0] = sp;
         12'(`MIE_OFS_WDOG):   w[15:0] = {wdog, presc};
         default: begin
            if (a >= `MIE_RF_BASE && a < `MIE_RF_BASE + 12'(4 * RF_DEPTH))
               w[7:0] = rf[a[8:2]];
         end
      endcase
      return w;
   endfunction

   // one wait state per transfer so read data always comes from a flop
   always_comb begin
      next_pend      = pend;
      next_pwr       = pwr;
      next_paddr     = paddr;
      next_hrdata    = hrdata;
      next_hreadyout = hreadyout;
      if (pend) begin
         if (!busy) begin
            next_pend      = 1'b0;
            next_hreadyout = 1'b1;
            if (!pwr)
               next_hrdata = rd_word(paddr);
         end
      end else if (hsel && htrans[1] && hready) begin
         next_pend      = 1'b1;
         next_pwr       = hwrite;
         next_paddr     = (haddr[31:12] == 20'h0) ? haddr[11:0] : 12'hffc;
         next_hreadyout = 1'b0;
      end
      next_osc = next_asleep;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend       <= 1'b0;
         pwr        <= 1'b0;
         paddr      <= 12'h000;
         hrdata     <= 32'h0000_0000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         osc_halted <= 1'b0;
      end else begin
         pend       <= next_pend;
         pwr        <= next_pwr;
         paddr      <= next_paddr;
         hrdata     <= next_hrdata;
         hreadyout  <= next_hreadyout;
         hresp      <= 1'b0;
         osc_halted <= next_osc;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   logic is_op_rot, is_op_ret, is_op_slp;
   assign is_op_rot = go && cmd.opcode == `MIE_OP_ROTR;
   assign is_op_ret = go && cmd.opcode == `MIE_OP_RET;
   assign is_op_slp = go && cmd.opcode == `MIE_OP_SLEEP;

   sequence s_ret_body;
      busy && pc == stk[sp] && sp == $past(sp) - 1'b1 ##1 !busy;
   endsequence

   AST_ROTR: assert property (is_op_rot && !cmd.dest |=>
      acc == {$past(flg.link), $past(opnd[7:1])} && flg.link == $past(opnd[0])
      && flg.null_result == $past(flg.null_result))
      else $error("rotate result or link wrong");
   AST_DEST_REG: assert property (go && cmd.opcode == `MIE_OP_XORF && cmd.dest |=>
      acc == $past(acc) && rf[$past(cmd.index)] == $past(acc ^ opnd))
      else $error("destination one did not write the register");
   AST_RET: assert property (is_op_ret |=> s_ret_body and flg == $past(flg))
      else $error("return sequence wrong");
   AST_SLP_WDOG: assert property (is_op_slp |=> wdog == 8'h00 && presc == 8'h00)
      else $error("watchdog not cleared by sleep");
   AST_SLP_FLAGS: assert property (is_op_slp |=>
      wd_exp && !pwr_dn && $stable(flg))
      else $error("sleep status bits wrong");
   AST_SLP_OSC: assert property (is_op_slp |=> asleep ##1 osc_halted)
      else $error("oscillator not halted after sleep");
   AST_SUBL: assert property (go && cmd.opcode == `MIE_OP_SUBL |=>
      acc == $past(cmd.literal - acc)
      && flg.link == ($past(cmd.literal) >= $past(acc))
      && flg.null_result == ($past(cmd.literal) == $past(acc)))
      else $error("literal subtraction wrong");
   AST_SUBF: assert property (go && cmd.opcode == `MIE_OP_SUBF && !cmd.dest |=>
      acc == $past(opnd - acc)
      && flg.half_borrow == ($past(opnd[3:0]) >= $past(acc[3:0])))
      else $error("register subtraction wrong");
   AST_XORL: assert property (go && cmd.opcode == `MIE_OP_XORL |=>
      acc == $past(acc ^ cmd.literal) && flg.link == $past(flg.link)
      && flg.null_result == (acc == 8'h00))
      else $error("literal xor wrong");
   AST_XORF: assert property (go && cmd.opcode == `MIE_OP_XORF && !cmd.dest |=>
      acc == $past(acc ^ opnd) && flg.half_borrow == $past(flg.half_borrow))
      else $error("register xor wrong");
   AST_SWAP: assert property (go && cmd.opcode == `MIE_OP_SWAP && !cmd.dest |=>
      acc == {$past(opnd[3:0]), $past(opnd[7:4])} && $stable(flg))
      else $error("nibble exchange wrong");

endmodule // mie_core

// file: mie_map.svh
// register offsets, opcodes, field positions and reset values of the execution core
`ifndef MIE_MAP_SVH
`define MIE_MAP_SVH

`define MIE_OFS_CMD      8'h00
`define MIE_OFS_ACC      8'h04
`define MIE_OFS_STATUS   8'h08
`define MIE_OFS_PC       8'h0c
`define MIE_OFS_PUSH     8'h10
`define MIE_OFS_WDOG     8'h14
`define MIE_OFS_WAKE     8'h18
`define MIE_RF_BASE      12'h200

`define MIE_OP_NOP       4'h0
`define MIE_OP_ROTR      4'h1
`define MIE_OP_RET       4'h2
`define MIE_OP_SLEEP     4'h3
`define MIE_OP_SUBL      4'h4
`define MIE_OP_SUBF      4'h5
`define MIE_OP_XORL      4'h6
`define MIE_OP_XORF      4'h7
`define MIE_OP_SWAP      4'h8

`define MIE_ST_LINK      0
`define MIE_ST_HALF      1
`define MIE_ST_NULL      2
`define MIE_ST_WDEXP     3
`define MIE_ST_PWRDN     4
`define MIE_ST_SLEEP     5
`define MIE_ST_BUSY      6

`define MIE_RST_ACC      8'h00
`define MIE_RST_PC       13'h0000
`define MIE_RST_WDEXP    1'b1
`define MIE_RST_PWRDN    1'b1
`define MIE_WDOG_CLR     8'h00

`endif

// file: mie_pkg.sv
// types shared by the execution core
package mie_pkg;
   typedef struct packed {
      logic [7:0] pad;
      logic [7:0] literal;
      logic       pad1;
      logic [6:0] index;
      logic [2:0] pad2;
      logic       dest;
      logic [3:0] opcode;
   } mie_cmd_s;

   typedef struct packed {
      logic link;
      logic half_borrow;
      logic null_result;
   } mie_flags_s;

   typedef struct packed {
      logic [7:0] value;
      mie_flags_s flags;
   } mie_alu_s;

   typedef enum logic [0:0] {EX_IDLE, EX_RET2} mie_exec_e;
endpackage

// file: mcu_instruction_subset_exec_tb.sv
// self-checking bench of the instruction execution core, driven over its register bus
`timescale 1ns/1ps
`include "mie_map.svh"
module mcu_instruction_subset_exec_tb;
   import mie_pkg::*;
   localparam logic [3:0] OP_ROT = 4'h1, OP_RET = 4'h2, OP_SLP = 4'h3, OP_SUBL = 4'h4;
   localparam logic [3:0] OP_SUBF = 4'h5, OP_XORL = 4'h6, OP_XORF = 4'h7, OP_SWP = 4'h8;
   logic        ref_clk;
   logic        sys_rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        osc_halted;
   int          bad_count;
   int          num_checks;
   int          cycles;

   mie_core dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_halted(osc_halted));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // hang guard: whole run needs about 1100 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask

   // entered just after a rising edge; every bus change is a non-blocking update
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsize  <= 3'b010;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] junk;
      xfer(1'b1, a, d, junk);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] want);
      logic [31:0] got;
      xfer(1'b0, a, 32'h0, got);
      check(got, want);
   endtask

   function automatic logic [31:0] rf_a(input logic [6:0] i);
      return {20'h0, `MIE_RF_BASE} + {23'h0, i, 2'b00};
   endfunction

   task automatic run_op(input logic [3:0] op, input logic d, input logic [6:0] idx,
                         input logic [7:0] lit, input logic [7:0] a0, input logic [7:0] r0,
                         input logic [31:0] s0);
      mie_cmd_s c;
      c = '0;
      c.opcode  = op;
      c.dest    = d;
      c.index   = idx;
      c.literal = lit;
      wr(`MIE_OFS_ACC, {24'h0, a0});
      wr(rf_a(idx), {24'h0, r0});
      wr(`MIE_OFS_STATUS, s0);
      wr(`MIE_OFS_CMD, c);
   endtask

   task automatic chk3(input logic [6:0] idx, input logic [7:0] ea, input logic [7:0] er,
                       input logic [31:0] es);
      rd_chk(`MIE_OFS_ACC, {24'h0, ea});
      rd_chk(rf_a(idx), {24'h0, er});
      rd_chk(`MIE_OFS_STATUS, es);
   endtask

   task automatic t_reset_and_map;
      rd_chk(`MIE_OFS_STATUS, 32'h18);
      rd_chk(`MIE_OFS_ACC, 32'h0);
      wr(32'h1000, 32'hff);
      rd_chk(32'h1000, 32'h0);
      check({31'h0, hresp}, 32'h0);
   endtask

   // two pops in a row; flags are checked after the first pop only
   task automatic t_return;
      wr(`MIE_OFS_PUSH, 32'h123);
      wr(`MIE_OFS_PUSH, 32'h1abc);
      rd_chk(`MIE_OFS_PUSH, 32'h2);
      wr(`MIE_OFS_STATUS, 32'h1f);
      wr(`MIE_OFS_CMD, {28'h0, OP_RET});
      rd_chk(`MIE_OFS_PC, 32'h1abc);
      rd_chk(`MIE_OFS_STATUS, 32'h1f);
      rd_chk(`MIE_OFS_PUSH, 32'h1);
      wr(`MIE_OFS_CMD, {28'h0, OP_RET});
      rd_chk(`MIE_OFS_PC, 32'h123);
   endtask

   task automatic t_rotate_swap;
      run_op(OP_ROT, 1'b1, 7'd5, 8'h00, 8'h11, 8'h81, 32'h1e);
      chk3(7'd5, 8'h11, 8'h40, 32'h1f);
      run_op(OP_ROT, 1'b0, 7'd127, 8'h00, 8'h11, 8'h02, 32'h19);
      chk3(7'd127, 8'h81, 8'h02, 32'h18);
      run_op(OP_SWP, 1'b1, 7'd9, 8'h00, 8'h77, 8'ha5, 32'h1f);
      chk3(7'd9, 8'h77, 8'h5a, 32'h1f);
      run_op(OP_SWP, 1'b0, 7'd10, 8'h00, 8'h77, 8'h3c, 32'h18);
      chk3(7'd10, 8'hc3, 8'h3c, 32'h18);
   endtask

   // zero result, full borrow, nibble-only borrow and byte-only borrow
   task automatic t_subtract;
      logic [7:0] m [4] = '{8'h05, 8'h05, 8'h20, 8'h1f};
      logic [7:0] s [4] = '{8'h05, 8'h06, 8'h1f, 8'h20};
      logic [7:0]  res;
      logic [31:0] es;
      for (int i = 0; i < 4; i++) begin
         res = m[i] - s[i];
         es  = {27'h0, 2'b11, res == 8'h0, m[i][3:0] >= s[i][3:0], m[i] >= s[i]};
         run_op(OP_SUBL, 1'b0, 7'd3, m[i], s[i], 8'h00, 32'h18);
         chk3(7'd3, res, 8'h00, es);
         run_op(OP_SUBF, 1'b1, 7'd127, 8'h00, s[i], m[i], 32'h18);
         chk3(7'd127, s[i], res, es);
         run_op(OP_SUBF, 1'b0, 7'd0, 8'h00, s[i], m[i], 32'h18);
         chk3(7'd0, res, m[i], es);
      end
   endtask

   task automatic t_xor;
      run_op(OP_XORL, 1'b0, 7'd1, 8'h3c, 8'h3c, 8'h00, 32'h1b);
      chk3(7'd1, 8'h00, 8'h00, 32'h1f);
      run_op(OP_XORL, 1'b0, 7'd1, 8'hff, 8'h3c, 8'h00, 32'h1f);
      chk3(7'd1, 8'hc3, 8'h00, 32'h1b);
      run_op(OP_XORF, 1'b1, 7'd64, 8'h00, 8'h55, 8'haa, 32'h1c);
      chk3(7'd64, 8'h55, 8'hff, 32'h18);
      run_op(OP_XORF, 1'b0, 7'd64, 8'h00, 8'h0f, 8'h0f, 32'h18);
      chk3(7'd64, 8'h00, 8'h0f, 32'h1c);
   endtask

   // watchdog is first let run so that its clearing is visible
   task automatic t_sleep;
      logic [31:0] got;
      repeat (600) @(posedge ref_clk);
      xfer(1'b0, `MIE_OFS_WDOG, 32'h0, got);
      check({31'h0, got[15:8] != 8'h00}, 32'h1);
      wr(`MIE_OFS_STATUS, 32'h17);
      wr(`MIE_OFS_CMD, {28'h0, OP_SLP});
      xfer(1'b0, `MIE_OFS_WDOG, 32'h0, got);
      check({31'h0, got[15:0] < 16'h0010}, 32'h1);
      rd_chk(`MIE_OFS_STATUS, 32'h2f);
      check({31'h0, osc_halted}, 32'h1);
      wr(`MIE_OFS_ACC, 32'h44);
      wr(`MIE_OFS_CMD, {8'h0, 8'hff, 12'h0, OP_XORL});
      rd_chk(`MIE_OFS_ACC, 32'h44);
      wr(`MIE_OFS_WAKE, 32'h0);
      repeat (2) @(posedge ref_clk);
      check({31'h0, osc_halted}, 32'h0);
   endtask

   initial begin
      bad_count  = 0;
      num_checks = 0;
      cycles     = 0;
      sys_rst    = 1'b1;
      hsel       = 1'b0;
      haddr      = 32'h0;
      htrans     = 2'b00;
      hwrite     = 1'b0;
      hsize      = 3'b010;
      hwdata     = 32'h0;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset_and_map();
      t_return();
      t_rotate_swap();
      t_subtract();
      t_xor();
      t_sleep();
      finish_test();
   end
endmodule // mcu_instruction_subset_exec_tb
